// ---- rtl/dts_cc_regs.vh ----
// constants for the debug accessory cc attach machine
// assumes a 10 mhz system clock and no software registers
`ifndef DTS_CC_REGS_VH
`define DTS_CC_REGS_VH

// clock rate in cycles per microsecond
`define CLK_MHZ 10

// durations in microseconds
`define T_ERR_REC_US 25000
`define T_CC_DEB_US 100000
`define T_PD_DEB_US 10000
`define T_DRP_US 75000
// source share of the toggle period, percent
`define DC_SRC_DRP_PCT 50

// port types
`define PORT_SINK 2'h0
`define PORT_SOURCE 2'h1
`define PORT_DRP 2'h2

// sensed level on one cc pin
`define CC_OPEN 2'h0
`define CC_RP 2'h1
`define CC_RD 2'h2

// termination request for one cc pin
`define TERM_NONE 2'h0
`define TERM_RD 2'h1
`define TERM_RP 2'h2

// state codes
`define ST_ERR_REC 4'h0
`define ST_DISABLED 4'h1
`define ST_UNATT_SNK 4'h2
`define ST_AWAIT_SNK 4'h3
`define ST_ATT_SNK 4'h4
`define ST_UNATT_SRC 4'h5
`define ST_TRY_SRC 4'h6

// cycles held in reset-release start-up
`define INIT_CYC 2'h3

`endif

// ---- rtl/dts_cc_timer.v ----
// one debounce or duration timer counting local clock cycles
// assumes run and clear come from logic on the same clock
`default_nettype none

module dts_cc_timer #(
  parameter integer W = 20,
  parameter [W-1:0] LIMIT = 20'h00001
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire clear_i,
  input wire run_i,
  output reg done_o
);

  reg [W-1:0] cnt_q;

  // restarts on clear or when its condition drops
  always @(posedge sys_clk_i) begin
    if (reset_i || clear_i || !run_i) begin
      cnt_q <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (!done_o) begin
      if (cnt_q >= LIMIT - {{(W-1){1'b0}}, 1'b1}) begin
        done_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // dts_cc_timer

`default_nettype wire

// ---- rtl/dts_cc_attach_fsm.v ----
// cc attach machine of a debug and test system plug port
// assumes analog comparators report each cc pin and vbus as pins
//
// Notes on behaviour
// - accessory recognised only when both cc pins show one termination
// - attach only to rp on both pins; rd on both or mixed is unsupported
// - pd over cc starts only after plug orientation is known
// - vconn is never driven in any state
// - error recovery drops all cc terminations, then goes unattached
// - a recovery directive enters error recovery from any state
// - without error recovery, go disabled, or else unattached
// - after recovery sink goes unattached sink, source and drp to src
// - dead battery port starts in unattached sink; sink and source rest there, drp toggles on
// - unattached and attach-wait sink: vbus undriven, rd on both pins
// - rp seen on both pins moves unattached sink to attach wait
// - drp toggles to source after open for sink share, or on demand
// - open for pd debounce leaves attach wait: sink back, drp to src
// - no open for cc debounce plus vbus: sink attaches, drp tries src
// - drp sequencing prefers the source role
// - attached sink never drives vbus
// - attached sink keeps rd on both pins, even when orientation is needed
// - attached sink keeps monitoring both cc pins and vbus
// - pd only after attached sink entry, in the ufp sink role
// - debug signals stay disconnected until attached
// - unworkable pairings leave both ports safe and unpowered
// - plug-side device sensing both cc wires independently
// - attached sink returns to unattached sink once vbus goes away
`default_nettype none
`include "dts_cc_regs.vh"

module dts_cc_attach_fsm #(
  parameter [1:0] PORT_TYPE = `PORT_DRP,
  parameter integer HAS_ERR_REC = 1,
  parameter integer HAS_DISABLED = 1,
  parameter integer T_ERR_REC_CYC = `T_ERR_REC_US * `CLK_MHZ,
  parameter integer T_CC_DEB_CYC = `T_CC_DEB_US * `CLK_MHZ,
  parameter integer T_PD_DEB_CYC = `T_PD_DEB_US * `CLK_MHZ,
  parameter integer T_DRP_SNK_CYC =
    (`T_DRP_US * (100 - `DC_SRC_DRP_PCT) / 100) * `CLK_MHZ,
  parameter integer T_DRP_SRC_CYC =
    (`T_DRP_US * `DC_SRC_DRP_PCT / 100) * `CLK_MHZ
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [1:0] cc1_sense_i,
  input wire [1:0] cc2_sense_i,
  input wire vbus_present_i,
  input wire dead_battery_i,
  input wire recover_req_i,
  input wire toggle_req_i,
  input wire orient_needed_i,
  input wire orient_known_i,
  output reg [1:0] cc1_term_o,
  output reg [1:0] cc2_term_o,
  output reg cc_monitor_o,
  output reg vbus_drive_o,
  output reg vconn_drive_o,
  output reg pd_enable_o,
  output reg pd_role_sink_o,
  output reg debug_connect_o,
  output reg attached_o,
  output reg [3:0] state_o
);

  localparam integer TW = 20;
  localparam integer NS = 10;

  // input synchroniser, two stages per pin
  wire [NS-1:0] raw_w;
  reg [NS-1:0] sync1_q;
  reg [NS-1:0] sync2_q;

  assign raw_w = {cc1_sense_i, cc2_sense_i, vbus_present_i,
                  dead_battery_i, recover_req_i, toggle_req_i,
                  orient_needed_i, orient_known_i};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_i) begin
        if (reset_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_w[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire [1:0] cc1_s;
  wire [1:0] cc2_s;
  wire vbus_s;
  wire dead_bat_s;
  wire recover_s;
  wire toggle_s;
  wire orient_need_s;
  wire orient_known_s;

  assign cc1_s = sync2_q[9:8];
  assign cc2_s = sync2_q[7:6];
  assign vbus_s = sync2_q[5];
  assign dead_bat_s = sync2_q[4];
  assign recover_s = sync2_q[3];
  assign toggle_s = sync2_q[2];
  assign orient_need_s = sync2_q[1];
  assign orient_known_s = sync2_q[0];

  // directives act on their rising edge
  reg recover_d1_q;
  reg toggle_d1_q;
  wire recover_evt;
  wire toggle_evt;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      recover_d1_q <= 1'b0;
      toggle_d1_q <= 1'b0;
    end else begin
      recover_d1_q <= recover_s;
      toggle_d1_q <= toggle_s;
    end
  end

  assign recover_evt = recover_s && !recover_d1_q;
  assign toggle_evt = toggle_s && !toggle_d1_q;

  // each pin judged on its own wire
  function both_is;
    input [1:0] a;
    input [1:0] b;
    input [1:0] lvl;
    begin
      both_is = (a == lvl) && (b == lvl);
    end
  endfunction

  // mixed terminations never count as a source
  wire both_rp;
  wire any_open;
  assign both_rp = both_is(cc1_s, cc2_s, `CC_RP);
  assign any_open = !both_rp;

  // unattached state that fits the port type
  function [3:0] unatt_for;
    input [1:0] ptype;
    begin
      if (ptype == `PORT_SINK) begin
        unatt_for = `ST_UNATT_SNK;
      end else begin
        unatt_for = `ST_UNATT_SRC;
      end
    end
  endfunction

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] init_q;
  wire state_chg;
  assign state_chg = (state_d != state_q);

  // qualifying conditions seen last cycle
  reg open_q;
  wire open_chg;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      open_q <= 1'b1;
    end else begin
      open_q <= any_open;
    end
  end
  assign open_chg = (open_q != any_open);

  // timers restart on state or condition change
  wire er_done;
  wire ccdeb_done;
  wire pddeb_done;
  wire drp_snk_done;
  wire drp_src_done;

  dts_cc_timer #(
    .W(TW),
    .LIMIT(T_ERR_REC_CYC[TW-1:0])
  ) u_er_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(state_chg),
    .run_i(state_q == `ST_ERR_REC),
    .done_o(er_done)
  );

  dts_cc_timer #(
    .W(TW),
    .LIMIT(T_CC_DEB_CYC[TW-1:0])
  ) u_ccdeb_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(state_chg || open_chg),
    .run_i((state_q == `ST_AWAIT_SNK) && !any_open),
    .done_o(ccdeb_done)
  );

  dts_cc_timer #(
    .W(TW),
    .LIMIT(T_PD_DEB_CYC[TW-1:0])
  ) u_pddeb_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(state_chg || open_chg),
    .run_i((state_q == `ST_AWAIT_SNK) && any_open),
    .done_o(pddeb_done)
  );

  dts_cc_timer #(
    .W(TW),
    .LIMIT(T_DRP_SNK_CYC[TW-1:0])
  ) u_drp_snk_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(state_chg || open_chg),
    .run_i((state_q == `ST_UNATT_SNK) && any_open),
    .done_o(drp_snk_done)
  );

  dts_cc_timer #(
    .W(TW),
    .LIMIT(T_DRP_SRC_CYC[TW-1:0])
  ) u_drp_src_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(state_chg),
    .run_i(state_q == `ST_UNATT_SRC),
    .done_o(drp_src_done)
  );

  wire is_drp;
  assign is_drp = (PORT_TYPE == `PORT_DRP);

  // next state
  always @* begin
    state_d = state_q;
    if (init_q != 2'h0) begin
      state_d = `ST_UNATT_SNK;
    end else if (recover_evt) begin
      if (HAS_ERR_REC != 0) begin
        state_d = `ST_ERR_REC;
      end else if (HAS_DISABLED != 0) begin
        state_d = `ST_DISABLED;
      end else begin
        state_d = unatt_for(PORT_TYPE);
      end
    end else begin
      case (state_q)
        `ST_ERR_REC: begin
          if (er_done) begin
            state_d = unatt_for(PORT_TYPE);
          end
        end
        `ST_DISABLED: begin
          state_d = `ST_DISABLED;
        end
        `ST_UNATT_SNK: begin
          if (both_rp) begin
            state_d = `ST_AWAIT_SNK;
          end else if (is_drp && (drp_snk_done || toggle_evt)) begin
            state_d = `ST_UNATT_SRC;
          end
        end
        `ST_AWAIT_SNK: begin
          if (pddeb_done) begin
            if (is_drp) begin
              state_d = `ST_UNATT_SRC;
            end else begin
              state_d = `ST_UNATT_SNK;
            end
          end else if (ccdeb_done && vbus_s) begin
            if (is_drp) begin
              state_d = `ST_TRY_SRC;
            end else begin
              state_d = `ST_ATT_SNK;
            end
          end
        end
        `ST_ATT_SNK: begin
          if (!vbus_s) begin
            state_d = `ST_UNATT_SNK;
          end
        end
        `ST_UNATT_SRC: begin
          if (is_drp && (drp_src_done || toggle_evt)) begin
            state_d = `ST_UNATT_SNK;
          end
        end
        `ST_TRY_SRC: begin
          state_d = `ST_TRY_SRC;
        end
        default: begin
          state_d = unatt_for(PORT_TYPE);
        end
      endcase
    end
  end

  // start in unattached sink; without dead battery, move to the type's unattached state once straps settle
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= `ST_UNATT_SNK;
      init_q <= `INIT_CYC;
    end else if (init_q != 2'h0) begin
      init_q <= init_q - 2'h1;
      if ((init_q == 2'h1) && !dead_bat_s) begin
        state_q <= unatt_for(PORT_TYPE);
      end
    end else begin
      state_q <= state_d;
    end
  end

  // terminations per state
  reg [1:0] term_d;
  reg att_d;
  always @* begin
    term_d = `TERM_NONE;
    att_d = 1'b0;
    case (state_q)
      `ST_ERR_REC: begin
        term_d = `TERM_NONE;
      end
      `ST_DISABLED: begin
        term_d = `TERM_NONE;
      end
      `ST_UNATT_SNK: begin
        term_d = `TERM_RD;
      end
      `ST_AWAIT_SNK: begin
        term_d = `TERM_RD;
      end
      `ST_ATT_SNK: begin
        term_d = `TERM_RD;
        att_d = 1'b1;
      end
      `ST_UNATT_SRC: begin
        term_d = `TERM_RP;
      end
      `ST_TRY_SRC: begin
        term_d = `TERM_RP;
      end
      default: begin
        term_d = `TERM_NONE;
      end
    endcase
  end

  // registered outputs
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      cc1_term_o <= `TERM_RD;
      cc2_term_o <= `TERM_RD;
      cc_monitor_o <= 1'b0;
      vbus_drive_o <= 1'b0;
      vconn_drive_o <= 1'b0;
      pd_enable_o <= 1'b0;
      pd_role_sink_o <= 1'b0;
      debug_connect_o <= 1'b0;
      attached_o <= 1'b0;
      state_o <= `ST_UNATT_SNK;
    end else begin
      cc1_term_o <= term_d;
      cc2_term_o <= term_d;
      cc_monitor_o <= att_d;
      vbus_drive_o <= 1'b0;
      vconn_drive_o <= 1'b0;
      pd_enable_o <= att_d && (orient_known_s || !orient_need_s)
                     && orient_known_s;
      pd_role_sink_o <= att_d;
      debug_connect_o <= att_d;
      attached_o <= att_d;
      state_o <= state_q;
    end
  end

endmodule // dts_cc_attach_fsm

`default_nettype wire

// ---- dv/dts_cc_attach_chk.sv ----
// checker for the cc attach machine, sink port type
// assumes shortened timer counts handed on by the bind
`default_nettype none
`include "dts_cc_regs.vh"
module dts_cc_attach_chk #(
  parameter integer T_ERR_REC_CYC = 20,
  parameter integer T_CC_DEB_CYC = 30,
  parameter integer T_PD_DEB_CYC = 12
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] cc1_sense_i,
  input wire logic [1:0] cc2_sense_i,
  input wire logic vbus_present_i,
  input wire logic orient_known_i,
  input wire logic [1:0] cc1_term_o,
  input wire logic [1:0] cc2_term_o,
  input wire logic cc_monitor_o,
  input wire logic vbus_drive_o,
  input wire logic vconn_drive_o,
  input wire logic pd_enable_o,
  input wire logic pd_role_sink_o,
  input wire logic debug_connect_o,
  input wire logic attached_o,
  input wire logic [3:0] state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] err_q;
  logic [15:0] aw_q;
  wire both_rp = cc1_sense_i == `CC_RP && cc2_sense_i == `CC_RP;
  wire rd_rd = cc1_term_o == `TERM_RD && cc2_term_o == `TERM_RD;
  // cycles spent in the current recovery or attach wait
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      err_q <= 16'h0000;
      aw_q <= 16'h0000;
    end else begin
      err_q <= (state_o == `ST_ERR_REC) ? err_q + 16'h0001 : 16'h0000;
      aw_q <= (state_o == `ST_AWAIT_SNK) ? aw_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  no_drive_a: assert property (!vconn_drive_o && !vbus_drive_o)
    else $error("vconn or vbus driven");
  attach_out_a: assert property (attached_o |-> debug_connect_o &&
    pd_role_sink_o && cc_monitor_o && rd_rd && state_o == `ST_ATT_SNK)
    else $error("attach flags");
  detach_out_a: assert property (!attached_o |->
    !debug_connect_o && !pd_enable_o && !cc_monitor_o &&
    state_o != `ST_ATT_SNK) else $error("early connect");
  pd_orient_a: assert property ($rose(pd_enable_o) |->
    attached_o && $past(orient_known_i, 2)) else $error("pd early");
  sink_terms_a: assert property ($past(state_o) == `ST_UNATT_SNK &&
    state_o == `ST_UNATT_SNK |-> rd_rd) else $error("sink terms");
  err_terms_a: assert property ($past(state_o) == `ST_ERR_REC &&
    state_o == `ST_ERR_REC |-> cc1_term_o == `TERM_NONE &&
    cc2_term_o == `TERM_NONE) else $error("recovery terms");
  err_len_a: assert property ($fell(state_o == `ST_ERR_REC) |->
    err_q >= T_ERR_REC_CYC && err_q <= T_ERR_REC_CYC + 4 &&
    state_o == `ST_UNATT_SNK) else $error("recovery length");
  attach_deb_a: assert property ($rose(state_o == `ST_ATT_SNK) |->
    aw_q >= T_CC_DEB_CYC && $past(vbus_present_i, 4))
    else $error("attach debounce");
  open_deb_a: assert property ($fell(state_o == `ST_AWAIT_SNK) &&
    state_o == `ST_UNATT_SNK |-> aw_q >= T_PD_DEB_CYC)
    else $error("open debounce");
  await_rp_a: assert property ($rose(state_o == `ST_AWAIT_SNK) |->
    $past(both_rp, 4)) else $error("await without rp");
  vbus_loss_a: assert property ($fell(vbus_present_i) && attached_o
    |-> ##[1:8] state_o == `ST_UNATT_SNK) else $error("vbus loss");
  cover property ($rose(attached_o));
  cover property ($fell(state_o == `ST_ERR_REC));
  cover property ($rose(pd_enable_o));
endmodule // dts_cc_attach_chk
bind dts_cc_attach_fsm dts_cc_attach_chk #(.T_ERR_REC_CYC(T_ERR_REC_CYC),
  .T_CC_DEB_CYC(T_CC_DEB_CYC), .T_PD_DEB_CYC(T_PD_DEB_CYC)) i_chk (
  .sys_clk_i, .reset_i, .cc1_sense_i, .cc2_sense_i, .vbus_present_i,
  .orient_known_i, .cc1_term_o, .cc2_term_o, .cc_monitor_o, .vbus_drive_o,
  .vconn_drive_o, .pd_enable_o, .pd_role_sink_o, .debug_connect_o,
  .attached_o, .state_o);
`default_nettype wire

// ---- dv/target_port_model.sv ----
// target port model presenting cc terminations and vbus
// assumes the bench changes the mode at a falling clock edge
`default_nettype none
`include "dts_cc_regs.vh"
module target_port_model (
  input wire logic [1:0] mode_i,
  input wire logic vbus_en_i,
  output logic [1:0] cc1_sense_o,
  output logic [1:0] cc2_sense_o,
  output logic vbus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // mode 0 removed, 1 source rp/rp, 2 sink rd/rd, 3 mixed rp/rd
  assign cc1_sense_o = (mode_i == 2'h2) ? `CC_RD :
    (mode_i == 2'h0) ? `CC_OPEN : `CC_RP;
  assign cc2_sense_o = (mode_i == 2'h1) ? `CC_RP :
    (mode_i == 2'h0) ? `CC_OPEN : `CC_RD;
  // only a source target powers vbus; no vconn at all
  assign vbus_o = vbus_en_i && mode_i == 2'h1;
endmodule // target_port_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// bench for the cc attach machine as a sink port
// assumes the target model and the bound checker
`default_nettype none
`include "dts_cc_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam integer T_ERR = 20;
  localparam integer T_CC = 30;
  localparam integer T_PD = 12;
  logic sys_clk_i, reset_i, recover_req_i, orient_known_i, vbus_en;
  logic toggle_req_i, orient_needed_i;
  logic [1:0] mode;
  wire [1:0] cc1_sense_i, cc2_sense_i, cc1_term_o, cc2_term_o;
  wire [3:0] state_o;
  wire vbus_present_i, cc_monitor_o, vbus_drive_o, vconn_drive_o;
  wire pd_enable_o, pd_role_sink_o, debug_connect_o, attached_o;
  int mismatches = 0;
  int n_compared = 0;
  int n;
  dts_cc_attach_fsm #(.PORT_TYPE(`PORT_SINK), .T_ERR_REC_CYC(T_ERR),
    .T_CC_DEB_CYC(T_CC), .T_PD_DEB_CYC(T_PD), .T_DRP_SNK_CYC(16),
    .T_DRP_SRC_CYC(16)) i_dut (.sys_clk_i, .reset_i, .cc1_sense_i,
    .cc2_sense_i, .vbus_present_i, .dead_battery_i(1'b1),
    .recover_req_i, .toggle_req_i, .orient_needed_i,
    .orient_known_i, .cc1_term_o, .cc2_term_o, .cc_monitor_o,
    .vbus_drive_o, .vconn_drive_o, .pd_enable_o, .pd_role_sink_o,
    .debug_connect_o, .attached_o, .state_o);
  target_port_model i_tgt (.mode_i(mode), .vbus_en_i(vbus_en),
    .cc1_sense_o(cc1_sense_i), .cc2_sense_o(cc2_sense_i),
    .vbus_o(vbus_present_i));
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] exp,
    input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    n = 0;
    while (state_o !== s && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("state_o", s, state_o);
  endtask
  task automatic t_attach();
    mode = 2'h1;
    wait_st(`ST_AWAIT_SNK, 8);
    vbus_en = 1'b1;
    wait_st(`ST_ATT_SNK, T_CC + 8);
    chk("debounce", 4'h1, {3'h0, n >= T_CC - 2});
    chk("flags", 4'hf, {attached_o, debug_connect_o, pd_role_sink_o,
      cc_monitor_o});
    chk("terms", 4'h5, {cc1_term_o, cc2_term_o});
    chk("pd_enable_o", 4'h0, {3'h0, pd_enable_o});
    orient_known_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    chk("pd", 4'h3, {2'h0, pd_enable_o, pd_role_sink_o});
  endtask
  task automatic t_vbus_loss();
    vbus_en = 1'b0;
    wait_st(`ST_UNATT_SNK, 8);
    chk("flags", 4'h0, {1'h0, attached_o, debug_connect_o,
      pd_enable_o});
    orient_known_i = 1'b0;
  endtask
  task automatic t_open();
    wait_st(`ST_AWAIT_SNK, 8);
    mode = 2'h0;
    repeat (T_PD - 4) @(negedge sys_clk_i);
    mode = 2'h1;
    repeat (8) @(negedge sys_clk_i);
    chk("state_o", `ST_AWAIT_SNK, state_o);
    mode = 2'h0;
    wait_st(`ST_UNATT_SNK, T_PD + 8);
    chk("open_wait", 4'h1, {3'h0, n >= T_PD});
  endtask
  task automatic t_mixed();
    mode = 2'h3;
    toggle_req_i = 1'b1;
    repeat (T_CC + T_PD) @(negedge sys_clk_i);
    toggle_req_i = 1'b0;
    chk("state_o", `ST_UNATT_SNK, state_o);
    mode = 2'h2;
    repeat (T_CC + T_PD) @(negedge sys_clk_i);
    chk("state_o", `ST_UNATT_SNK, state_o);
    chk("drives", 4'h0, {2'h0, vbus_drive_o, vconn_drive_o});
  endtask
  task automatic t_recover();
    orient_needed_i = 1'b1;
    t_attach();
    recover_req_i = 1'b1;
    wait_st(`ST_ERR_REC, 8);
    recover_req_i = 1'b0;
    @(negedge sys_clk_i);
    chk("terms", 4'h0, {cc1_term_o, cc2_term_o});
    wait_st(`ST_UNATT_SNK, T_ERR + 8);
    chk("recovery", 4'h1, {3'h0, n >= T_ERR - 3});
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    reset_i = 1'b1;
    mode = 2'h0;
    vbus_en = 1'b0;
    recover_req_i = 1'b0;
    orient_known_i = 1'b0;
    toggle_req_i = 1'b0;
    orient_needed_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    reset_i = 1'b0;
    chk("state_o", `ST_UNATT_SNK, state_o);
    chk("terms", 4'h5, {cc1_term_o, cc2_term_o});
    repeat (4) @(negedge sys_clk_i);
    t_attach();
    t_vbus_loss();
    t_open();
    t_mixed();
    t_recover();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    mismatches++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
